// ===== logic/fault_status_pkg.sv
// constants shared by the fault status register bank
package fault_status_pkg;
    localparam logic [6:0] SUPPLY_ADDR = 7'h41;
    localparam logic [6:0] THERMAL_ADDR = 7'h42;
    localparam logic [6:0] DEVICE_ADDR = 7'h43;
    localparam logic [6:0] BUS_ADDR = 7'h44;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_LSB = 0;
    localparam int ACCESS_BIT = 7;
    localparam logic [7:0] SUPPLY_RST = 8'h80;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [7:0] SUPPLY_MASK = 8'hfd;
    localparam logic [7:0] THERMAL_MASK = 8'h07;
    localparam logic [7:0] BUS_MASK = 8'h67;
    localparam int SUP_POR = 7;
    localparam int SUP_LIN_UV = 6;
    localparam int SUP_MAIN_OV = 5;
    localparam int SUP_SEC_OT = 4;
    localparam int SUP_SEC_UV = 3;
    localparam int SUP_MAIN_SC = 2;
    localparam int SUP_MAIN_UV = 0;
    localparam int TH_SEVERE = 2;
    localparam int TH_FIRST = 1;
    localparam int TH_PREWARN = 0;
    localparam int DEV_PRIOR_LSB = 6;
    localparam int DEV_CLAMP = 5;
    localparam int DEV_FSI = 4;
    localparam int DEV_WD_LSB = 2;
    localparam int DEV_SPI = 1;
    localparam int DEV_FO = 0;
    localparam int BUS_LIN_LSB = 5;
    localparam int BUS_CAN_LSB = 1;
    localparam int BUS_CAN_UV = 0;
    localparam logic [1:0] PRIOR_FAIL = 2'b01;
    localparam logic [1:0] PRIOR_SLEEP = 2'b10;
    localparam logic [1:0] WD_MAX = 2'b10;
    localparam logic [1:0] CODE_TSD = 2'b01;
    localparam logic [1:0] CODE_TXD = 2'b10;
    localparam logic [1:0] CODE_BUS = 2'b11;
    localparam logic [1:0] TRX_OFF = 2'b00;
    localparam logic [1:0] TRX_WAKE = 2'b01;
    localparam logic [1:0] TRX_RXONLY = 2'b10;
    localparam logic [1:0] TRX_NORMAL = 2'b11;
    localparam int TX_ENABLE_NS = 10000;
    localparam int CLK_NS = 10;
    localparam int TX_ENABLE_CYC = (TX_ENABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TXC_W = 10;
endpackage

// ===== logic/transceiver_guard.sv
// per-transceiver fault code and transmitter re-enable logic
`timescale 1ns/10ps
module transceiver_guard
    import fault_status_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [1:0] mode_i,
    input wire logic tsd_i,
    input wire logic txd_dom_i,
    input wire logic bus_dom_i,
    input wire logic txd_high_i,
    input wire logic bus_recessive_i,
    input wire logic uv_i,
    output logic [1:0] code_o,
    output logic tx_en_o
);
    logic fault_r;
    logic [TXC_W-1:0] cnt_r;
    logic idle;
    assign idle = (mode_i == TRX_OFF) || (mode_i == TRX_WAKE);
    always_comb begin
        if (tsd_i) begin
            code_o = CODE_TSD;
        end else if (bus_dom_i && !(bus_recessive_i || idle)) begin
            code_o = CODE_BUS;
        end else if (txd_dom_i && !(txd_high_i || idle)) begin
            code_o = CODE_TXD;
        end else begin
            code_o = 2'b00;
        end
    end
    // transmitter stays off after a fault until data high for the enable time
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            fault_r <= 1'b0;
            cnt_r <= '0;
        end else if (ce_i) begin
            if (code_o != 2'b00 || uv_i) begin
                fault_r <= 1'b1;
                cnt_r <= '0;
            end else if (fault_r) begin
                if (!txd_high_i) begin
                    cnt_r <= '0;
                end else if (cnt_r == TXC_W'(TX_ENABLE_CYC - 1)) begin
                    fault_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
    assign tx_en_o = !fault_r && code_o == 2'b00 && !uv_i;
endmodule

// ===== logic/status_flag_byte.sv
// eight sticky flags with host clear, set winning over clear
`timescale 1ns/10ps
module status_flag_byte
    import fault_status_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [7:0] rst_val_i,
    input wire logic [7:0] mask_i,
    input wire logic [7:0] set_i,
    input wire logic clr_i,
    output logic [7:0] flags_o
);
    logic [7:0] flags_r;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gbit
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    flags_r[g] <= rst_val_i[g] & mask_i[g];
                end else if (ce_i) begin
                    if (set_i[g] && mask_i[g]) begin
                        flags_r[g] <= 1'b1;
                    end else if (clr_i) begin
                        flags_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign flags_o = flags_r;
endmodule

// ===== logic/fault_status_bank.sv
// fault status register bank behind a 16-bit serial command port
`timescale 1ns/10ps
module fault_status_bank
    import fault_status_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic soft_rst_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_frame_i,
    input wire logic cmd_invalid_i,
    input wire logic por_i,
    input wire logic main_reg_on_i,
    input wire logic second_reg_on_i,
    input wire logic [1:0] lin_mode_i,
    input wire logic [1:0] can_mode_i,
    input wire logic can_wake_seen_i,
    input wire logic overvolt_reset_enable_i,
    input wire logic main_uv_i,
    input wire logic main_ov_i,
    input wire logic main_sc_i,
    input wire logic second_uv_i,
    input wire logic second_ot_i,
    input wire logic lin_supply_uv_i,
    input wire logic can_supply_uv_i,
    input wire logic severe_tsd_i,
    input wire logic first_tsd_i,
    input wire logic prewarn_i,
    input wire logic reset_clamped_i,
    input wire logic failsafe_input_bad_i,
    input wire logic fail_outputs_on_i,
    input wire logic watchdog_fail_counter_i,
    input wire logic wd_good_i,
    input wire logic restart_i,
    input wire logic restart_fail_i,
    input wire logic restart_sleep_i,
    input wire logic lin_tsd_i,
    input wire logic lin_txdata_dominant_timeout_i,
    input wire logic lin_bus_dominant_timeout_i,
    input wire logic lin_txd_high_i,
    input wire logic lin_recessive_i,
    input wire logic can_tsd_i,
    input wire logic can_txdata_dominant_timeout_i,
    input wire logic can_bus_dominant_timeout_i,
    input wire logic can_txd_high_i,
    input wire logic can_recessive_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic cmd_reject_o,
    output logic failsafe_req_o,
    output logic lin_tx_en_o,
    output logic can_tx_en_o
);
    // pin-level inputs pass a three-stage synchroniser; a change counts when stages 2 and 3 agree
    localparam int NSYNC = 17;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    logic [NSYNC-1:0] lvl_r;
    assign raw = {main_uv_i, main_ov_i, main_sc_i, second_uv_i, second_ot_i, lin_supply_uv_i,
                  can_supply_uv_i, severe_tsd_i, first_tsd_i, prewarn_i, reset_clamped_i,
                  lin_txd_high_i, lin_recessive_i, can_txd_high_i, can_recessive_i,
                  failsafe_input_bad_i, por_i};
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end else if (ce_i) begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    lvl_r[i] <= s3_r[i];
                end
            end
        end
    end
    logic m_uv, m_ov, m_sc, s_uv, s_ot, l_uv, c_uv, t_sev, t_first, t_pw, clamp;
    logic l_txh, l_rec, c_txh, c_rec, fsi_bad, por_seen;
    assign {m_uv, m_ov, m_sc, s_uv, s_ot, l_uv, c_uv, t_sev, t_first, t_pw, clamp,
            l_txh, l_rec, c_txh, c_rec, fsi_bad, por_seen} = lvl_r;

    // command decode
    function automatic logic hits(input logic [15:0] f, input logic [6:0] a);
        return f[8 + ADDR_LSB +: 7] == a;
    endfunction
    logic good_cmd;
    logic clr_cmd;
    logic clr_sup, clr_th, clr_dev, clr_bus;
    logic bank_rst;
    assign bank_rst = srst_i || soft_rst_i;
    assign good_cmd = cmd_valid_i && !cmd_invalid_i;
    assign clr_cmd = good_cmd && cmd_frame_i[ACCESS_BIT + 8];
    assign clr_sup = clr_cmd && hits(cmd_frame_i, SUPPLY_ADDR);
    assign clr_th = clr_cmd && hits(cmd_frame_i, THERMAL_ADDR);
    assign clr_dev = clr_cmd && hits(cmd_frame_i, DEVICE_ADDR);
    assign clr_bus = clr_cmd && hits(cmd_frame_i, BUS_ADDR);

    // supply flags with suppression while the regulator or LINs are inactive
    logic lin_active;
    logic [7:0] sup_set;
    logic [7:0] sup_q;
    assign lin_active = (lin_mode_i == TRX_RXONLY) || (lin_mode_i == TRX_NORMAL);
    always_comb begin
        sup_set = 8'h00;
        sup_set[SUP_POR] = por_seen;
        sup_set[SUP_LIN_UV] = l_uv && lin_active;
        sup_set[SUP_MAIN_OV] = m_ov;
        sup_set[SUP_SEC_OT] = s_ot && second_reg_on_i;
        sup_set[SUP_SEC_UV] = s_uv && second_reg_on_i;
        sup_set[SUP_MAIN_SC] = m_sc && main_reg_on_i;
        sup_set[SUP_MAIN_UV] = m_uv && main_reg_on_i;
    end
    // soft reset leaves the power-on history alone, only a true reset loads it
    status_flag_byte u_sup (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .rst_val_i(SUPPLY_RST),
        .mask_i(SUPPLY_MASK),
        .set_i(sup_set),
        .clr_i(clr_sup),
        .flags_o(sup_q)
    );

    logic [7:0] th_set;
    logic [7:0] th_q;
    logic lin_first_tsd, can_first_tsd;
    assign th_set = {5'b0, t_sev, t_first || lin_first_tsd || can_first_tsd, t_pw};
    status_flag_byte u_th (
        .mclk_i(mclk_i),
        .srst_i(bank_rst),
        .ce_i(ce_i),
        .rst_val_i(ZERO_RST),
        .mask_i(THERMAL_MASK),
        .set_i(th_set),
        .clr_i(clr_th),
        .flags_o(th_q)
    );

    // device history register
    logic [1:0] prior_state_field_r;
    logic reset_clamped_high_flag_r, failsafe_input_fail_flag_r;
    logic [1:0] watchdog_fail_counter_r;
    logic spi_fail_r, fail_outputs_active_flag_r;
    logic ov_counts;
    assign ov_counts = m_ov && overvolt_reset_enable_i;
    always_ff @(posedge mclk_i) begin
        if (bank_rst) begin
            prior_state_field_r <= 2'b00;
        end else if (ce_i) begin
            if (restart_i && (restart_fail_i || ov_counts)) begin
                prior_state_field_r <= PRIOR_FAIL;
            end else if (restart_i && restart_sleep_i) begin
                prior_state_field_r <= PRIOR_SLEEP;
            end else if (clr_dev) begin
                prior_state_field_r <= 2'b00;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (bank_rst) begin
            reset_clamped_high_flag_r <= 1'b0;
            failsafe_input_fail_flag_r <= 1'b0;
            spi_fail_r <= 1'b0;
            fail_outputs_active_flag_r <= 1'b0;
        end else if (ce_i) begin
            reset_clamped_high_flag_r <= clamp || (reset_clamped_high_flag_r && !clr_dev);
            failsafe_input_fail_flag_r <= fsi_bad
                || (failsafe_input_fail_flag_r && !clr_dev);
            spi_fail_r <= (cmd_valid_i && cmd_invalid_i) || (spi_fail_r && !clr_dev);
            fail_outputs_active_flag_r <= fail_outputs_on_i
                || (fail_outputs_active_flag_r && !clr_dev);
        end
    end
    // counter ignores the host clear; only a good trigger empties it
    always_ff @(posedge mclk_i) begin
        if (bank_rst) begin
            watchdog_fail_counter_r <= 2'b00;
        end else if (ce_i) begin
            if (watchdog_fail_counter_i && watchdog_fail_counter_r != WD_MAX) begin
                watchdog_fail_counter_r <= watchdog_fail_counter_r + 2'b01;
            end else if (wd_good_i && !watchdog_fail_counter_i) begin
                watchdog_fail_counter_r <= 2'b00;
            end
        end
    end
    logic [7:0] dev_q;
    assign dev_q = {prior_state_field_r, reset_clamped_high_flag_r, failsafe_input_fail_flag_r,
                    watchdog_fail_counter_r, spi_fail_r, fail_outputs_active_flag_r};

    // bus faults
    logic [1:0] lin_code, can_code;
    logic lin_tx_ok, can_tx_ok;
    logic can_uv_on;
    assign can_uv_on = (can_mode_i == TRX_NORMAL) || (can_mode_i == TRX_RXONLY)
        || ((can_mode_i == TRX_WAKE) && can_wake_seen_i);
    transceiver_guard u_lin (
        .mclk_i(mclk_i),
        .srst_i(bank_rst),
        .ce_i(ce_i),
        .mode_i(lin_mode_i),
        .tsd_i(lin_tsd_i),
        .txd_dom_i(lin_txdata_dominant_timeout_i),
        .bus_dom_i(lin_bus_dominant_timeout_i),
        .txd_high_i(l_txh),
        .bus_recessive_i(l_rec),
        .uv_i(l_uv && lin_active),
        .code_o(lin_code),
        .tx_en_o(lin_tx_ok)
    );
    transceiver_guard u_can (
        .mclk_i(mclk_i),
        .srst_i(bank_rst),
        .ce_i(ce_i),
        .mode_i(can_mode_i),
        .tsd_i(can_tsd_i),
        .txd_dom_i(can_txdata_dominant_timeout_i),
        .bus_dom_i(can_bus_dominant_timeout_i),
        .txd_high_i(c_txh),
        .bus_recessive_i(c_rec),
        .uv_i(c_uv && can_uv_on),
        .code_o(can_code),
        .tx_en_o(can_tx_ok)
    );
    assign lin_first_tsd = lin_code == CODE_TSD;
    assign can_first_tsd = can_code == CODE_TSD;
    // a code change overwrites the held code; clear wins only when no fault is active
    logic [1:0] lin_one_fault_code_r, can_code_r;
    logic can_supply_undervolt_flag_r;
    always_ff @(posedge mclk_i) begin
        if (bank_rst) begin
            lin_one_fault_code_r <= 2'b00;
            can_code_r <= 2'b00;
            can_supply_undervolt_flag_r <= 1'b0;
        end else if (ce_i) begin
            if (lin_code != 2'b00) begin
                lin_one_fault_code_r <= lin_code;
            end else if (clr_bus) begin
                lin_one_fault_code_r <= 2'b00;
            end
            if (can_code != 2'b00) begin
                can_code_r <= can_code;
            end else if (clr_bus) begin
                can_code_r <= 2'b00;
            end
            can_supply_undervolt_flag_r <= (c_uv && can_uv_on)
                || (can_supply_undervolt_flag_r && !clr_bus);
        end
    end
    logic [7:0] bus_q;
    assign bus_q = {1'b0, lin_one_fault_code_r, 2'b00, can_code_r,
                    can_supply_undervolt_flag_r} & BUS_MASK;

    // read path: data shows the value before any clear of the same frame
    logic [7:0] rd_sel;
    always_comb begin
        unique case (cmd_frame_i[14:8])
            SUPPLY_ADDR: rd_sel = sup_q & SUPPLY_MASK;
            THERMAL_ADDR: rd_sel = th_q & THERMAL_MASK;
            DEVICE_ADDR: rd_sel = dev_q;
            BUS_ADDR: rd_sel = bus_q;
            default: rd_sel = 8'h00;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 8'h00;
            cmd_reject_o <= 1'b0;
        end else if (ce_i) begin
            rd_valid_o <= good_cmd;
            cmd_reject_o <= cmd_valid_i && cmd_invalid_i;
            if (good_cmd) begin
                rd_data_o <= rd_sel;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            failsafe_req_o <= 1'b0;
            lin_tx_en_o <= 1'b0;
            can_tx_en_o <= 1'b0;
        end else if (ce_i) begin
            failsafe_req_o <= t_sev;
            lin_tx_en_o <= lin_tx_ok && lin_active;
            can_tx_en_o <= can_tx_ok && !(c_uv && can_uv_on);
        end
    end
endmodule

// ===== test/fault_status_bank_assertions.sv
// concurrent checks on the fault status bank ports
`timescale 1ns/10ps
module fault_status_bank_chk
    import fault_status_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_frame_i,
    input wire logic cmd_invalid_i,
    input wire logic severe_tsd_i,
    input wire logic can_supply_uv_i,
    input wire logic [1:0] can_mode_i,
    input wire logic can_txdata_dominant_timeout_i,
    input wire logic can_txd_high_i,
    input wire logic lin_txdata_dominant_timeout_i,
    input wire logic lin_txd_high_i,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic cmd_reject_o,
    input wire logic failsafe_req_o,
    input wire logic lin_tx_en_o,
    input wire logic can_tx_en_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    logic [6:0] addr_q;
    logic [7:0] rmask;
    logic [10:0] hi_cnt;
    logic flt_seen;
    always_ff @(posedge mclk_i) begin
        addr_q <= cmd_frame_i[14:8];
    end
    // raw count runs ahead of the synced one, so it is a safe upper bound
    always_ff @(posedge mclk_i) begin
        if (srst_i || !can_txd_high_i) begin
            hi_cnt <= 11'h000;
        end else if (hi_cnt != 11'h7ff) begin
            hi_cnt <= hi_cnt + 11'h001;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flt_seen <= 1'b0;
        end else if (can_txdata_dominant_timeout_i) begin
            flt_seen <= 1'b1;
        end
    end
    always_comb begin
        case (addr_q)
            SUPPLY_ADDR: rmask = SUPPLY_MASK;
            THERMAL_ADDR: rmask = THERMAL_MASK;
            DEVICE_ADDR: rmask = 8'hff;
            BUS_ADDR: rmask = BUS_MASK;
            default: rmask = 8'h00;
        endcase
    end
    chk_read_answer: assert property (ce_i && cmd_valid_i && !cmd_invalid_i |=> rd_valid_o)
        else $error("read frame not answered");
    chk_bad_refused: assert property (ce_i && cmd_valid_i && cmd_invalid_i |=> cmd_reject_o && !rd_valid_o)
        else $error("invalid frame not refused");
    chk_no_stray: assert property (!(ce_i && cmd_valid_i) |=> !rd_valid_o && !cmd_reject_o)
        else $error("answer without frame");
    chk_reserved_zero: assert property (rd_valid_o |-> (rd_data_o & ~rmask) == 8'h00)
        else $error("reserved or unmapped bit reads one");
    chk_data_held: assert property (!rd_valid_o |-> $stable(rd_data_o))
        else $error("read data changed without a read");
    chk_failsafe_rise: assert property ($rose(severe_tsd_i) |-> ##[2:6] failsafe_req_o)
        else $error("severe shutdown without fail-safe");
    chk_canuv_txoff: assert property ((can_supply_uv_i && can_mode_i == TRX_NORMAL)[*8] |-> !can_tx_en_o)
        else $error("transmitter on during supply undervoltage");
    // data-high input is synchronised, so the fault shows a few cycles late
    chk_txd_dom_off: assert property ((lin_txdata_dominant_timeout_i && !lin_txd_high_i)[*8] |-> !lin_tx_en_o)
        else $error("transmitter on after dominant timeout");
    chk_tx_reenable: assert property ($rose(can_tx_en_o) && flt_seen |-> int'(hi_cnt) >= TX_ENABLE_CYC)
        else $error("transmitter back before enable time");
endmodule

// ===== test/status_host_model.sv
// host side model issuing 16-bit status frames
`timescale 1ns/10ps
module status_host_model (
    input wire logic mclk_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    input wire logic cmd_reject_i,
    output logic cmd_valid_o,
    output logic [15:0] cmd_frame_o,
    output logic cmd_invalid_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_frame_o = 16'h0000;
        cmd_invalid_o = 1'b0;
    end
    // one frame, then four edges at most for the answer; resp is {refused, answered}
    task automatic access(input logic [6:0] addr, input logic clr, input logic bad,
                          output logic [7:0] data, output logic [1:0] resp);
        logic [15:0] frm;
        frm = {clr, addr, 8'h5a};
        resp = 2'b00;
        data = 8'h00;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_frame_o <= frm;
        cmd_invalid_o <= bad;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        // released frame must not look like the last one
        cmd_frame_o <= ~frm;
        cmd_invalid_o <= 1'b0;
        for (int i = 0; i < 4 && resp == 2'b00; i++) begin
            @(posedge mclk_i);
            resp = {cmd_reject_i, rd_valid_i};
            data = rd_data_i;
        end
    endtask
endmodule

// ===== test/fault_status_bank_tb_top.sv
// self-checking bench for the fault status register bank
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module fault_status_bank_tb_top
    import fault_status_pkg::*;
;
    logic mclk_i, srst_i, ce_i, soft_rst_i, main_reg_on_i, second_reg_on_i, can_wake_seen_i;
    logic overvolt_reset_enable_i, fail_outputs_on_i, watchdog_fail_counter_i, wd_good_i, restart_i;
    logic restart_fail_i, restart_sleep_i, reset_clamped_i, failsafe_input_bad_i;
    logic lin_txd_high_i, lin_recessive_i, can_txd_high_i, can_recessive_i;
    logic [1:0] lin_mode_i, can_mode_i, r;
    logic [2:0] thm, linf;
    logic [3:0] canf;
    logic [7:0] sup, d;
    int mismatches = 0;
    int compares = 0;
    wire cmd_valid_i, cmd_invalid_i, rd_valid_o, cmd_reject_o, failsafe_req_o;
    wire lin_tx_en_o, can_tx_en_o;
    wire [15:0] cmd_frame_i;
    wire [7:0] rd_data_o;
    wire por_i = sup[7], lin_supply_uv_i = sup[6], main_ov_i = sup[5], second_ot_i = sup[4];
    wire second_uv_i = sup[3], main_sc_i = sup[2], main_uv_i = sup[0];
    wire severe_tsd_i = thm[2], first_tsd_i = thm[1], prewarn_i = thm[0];
    wire lin_tsd_i = linf[0], lin_txdata_dominant_timeout_i = linf[1], lin_bus_dominant_timeout_i = linf[2];
    wire can_tsd_i = canf[0], can_txdata_dominant_timeout_i = canf[1], can_bus_dominant_timeout_i = canf[2];
    wire can_supply_uv_i = canf[3];
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    fault_status_bank u_dut (.*);
    status_host_model u_host (
        .mclk_i(mclk_i),
        .rd_valid_i(rd_valid_o),
        .rd_data_i(rd_data_o),
        .cmd_reject_i(cmd_reject_o),
        .cmd_valid_o(cmd_valid_i),
        .cmd_frame_o(cmd_frame_i),
        .cmd_invalid_o(cmd_invalid_i)
    );
    task automatic finish_test();
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic xfer(input logic [6:0] a, input logic c, input logic bad, input logic [7:0] e);
        u_host.access(a, c, bad, d, r);
        `CHK(r, bad ? 2'b10 : 2'b01)
        if (!bad) `CHK(d, e)
        if (r === 2'b00) finish_test();
    endtask
    task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e);
        xfer(a, c, 1'b0, e);
    endtask
    task automatic restart(input logic f, input logic s);
        restart_fail_i <= f;
        restart_sleep_i <= s;
        restart_i <= 1'b1;
        tick(1);
        restart_i <= 1'b0;
    endtask
    // fault on one transceiver, recovery, then the transmitter waits out the enable time
    task automatic bus_case(input int t, input int k);
        logic [7:0] e;
        e = (t == 0) ? 8'(k << 5) : ((k == 4) ? 8'h01 : 8'(k << 1));
        {lin_txd_high_i, lin_recessive_i, can_txd_high_i, can_recessive_i} <= 4'h0;
        if (t == 0) linf <= 3'(1 << (k - 1));
        else canf <= 4'(1 << (k - 1));
        tick(10);
        `CHK(t ? can_tx_en_o : lin_tx_en_o, 1'b0)
        linf <= 3'h0;
        canf <= 4'h0;
        {lin_txd_high_i, lin_recessive_i, can_txd_high_i, can_recessive_i} <= 4'hf;
        tick(TX_ENABLE_CYC - 2);
        `CHK(t ? can_tx_en_o : lin_tx_en_o, 1'b0)
        tick(16);
        `CHK(t ? can_tx_en_o : lin_tx_en_o, 1'b1)
        rd(BUS_ADDR, 1'b1, e);
        rd(BUS_ADDR, 1'b0, 8'h00);
        if (k == 1) rd(THERMAL_ADDR, 1'b1, 8'h02);
    endtask
    initial begin
        srst_i = 1'b1;
        ce_i = 1'b1;
        {soft_rst_i, can_wake_seen_i, overvolt_reset_enable_i, fail_outputs_on_i} = 4'h0;
        {watchdog_fail_counter_i, wd_good_i, restart_i, restart_fail_i, restart_sleep_i} = 5'h00;
        {reset_clamped_i, failsafe_input_bad_i, main_reg_on_i, second_reg_on_i} = 4'h3;
        {lin_txd_high_i, lin_recessive_i, can_txd_high_i, can_recessive_i} = 4'hf;
        lin_mode_i = TRX_NORMAL;
        can_mode_i = TRX_NORMAL;
        {sup, thm, linf, canf} = '0;
        tick(3);
        srst_i <= 1'b0;
        tick(8);
        rd(SUPPLY_ADDR, 1'b0, SUPPLY_RST);
        rd(SUPPLY_ADDR, 1'b1, SUPPLY_RST);
        rd(SUPPLY_ADDR, 1'b0, 8'h00);
        for (int a = 0; a < 4; a++) rd(7'(THERMAL_ADDR + a), 1'b0, 8'h00);
        for (int b = 0; b < 8; b++) begin
            sup <= 8'(1 << b);
            tick(8);
            sup <= 8'h00;
            tick(8);
            rd(SUPPLY_ADDR, 1'b0, 8'(1 << b) & SUPPLY_MASK);
            rd(SUPPLY_ADDR, 1'b1, 8'(1 << b) & SUPPLY_MASK);
            rd(SUPPLY_ADDR, 1'b0, 8'h00);
        end
        {main_reg_on_i, second_reg_on_i} <= 2'b00;
        lin_mode_i <= TRX_WAKE;
        sup <= 8'h7d;
        tick(8);
        rd(SUPPLY_ADDR, 1'b1, 8'h20);
        lin_mode_i <= TRX_OFF;
        tick(2);
        rd(SUPPLY_ADDR, 1'b1, 8'h20);
        sup <= 8'h00;
        tick(8);
        {main_reg_on_i, second_reg_on_i} <= 2'b11;
        lin_mode_i <= TRX_NORMAL;
        thm <= 3'h7;
        tick(8);
        `CHK(failsafe_req_o, 1'b1)
        thm <= 3'h0;
        tick(8);
        rd(THERMAL_ADDR, 1'b0, 8'h07);
        soft_rst_i <= 1'b1;
        tick(1);
        soft_rst_i <= 1'b0;
        rd(THERMAL_ADDR, 1'b0, 8'h00);
        rd(SUPPLY_ADDR, 1'b0, 8'h20);
        lin_mode_i <= TRX_RXONLY;
        sup <= 8'h40;
        tick(8);
        sup <= 8'h00;
        tick(8);
        rd(SUPPLY_ADDR, 1'b1, 8'h60);
        lin_mode_i <= TRX_NORMAL;
        {reset_clamped_i, failsafe_input_bad_i, fail_outputs_on_i} <= 3'h7;
        repeat (3) begin
            watchdog_fail_counter_i <= 1'b1;
            tick(1);
            watchdog_fail_counter_i <= 1'b0;
            tick(1);
        end
        {reset_clamped_i, failsafe_input_bad_i, fail_outputs_on_i} <= 3'h0;
        tick(8);
        rd(DEVICE_ADDR, 1'b1, 8'h39);
        rd(DEVICE_ADDR, 1'b0, 8'h08);
        xfer(DEVICE_ADDR, 1'b1, 1'b1, 8'h00);
        rd(DEVICE_ADDR, 1'b0, 8'h0a);
        wd_good_i <= 1'b1;
        tick(1);
        wd_good_i <= 1'b0;
        rd(DEVICE_ADDR, 1'b1, 8'h02);
        fail_outputs_on_i <= 1'b1;
        tick(2);
        rd(DEVICE_ADDR, 1'b1, 8'h01);
        rd(DEVICE_ADDR, 1'b0, 8'h01);
        fail_outputs_on_i <= 1'b0;
        rd(DEVICE_ADDR, 1'b1, 8'h01);
        ce_i <= 1'b0;
        fail_outputs_on_i <= 1'b1;
        tick(2);
        fail_outputs_on_i <= 1'b0;
        ce_i <= 1'b1;
        rd(DEVICE_ADDR, 1'b0, 8'h00);
        overvolt_reset_enable_i <= 1'b1;
        sup <= 8'h20;
        tick(8);
        restart(1'b0, 1'b0);
        rd(DEVICE_ADDR, 1'b1, 8'h40);
        overvolt_reset_enable_i <= 1'b0;
        restart(1'b0, 1'b0);
        rd(DEVICE_ADDR, 1'b1, 8'h00);
        sup <= 8'h00;
        restart(1'b0, 1'b1);
        rd(DEVICE_ADDR, 1'b1, 8'h80);
        restart(1'b1, 1'b1);
        rd(DEVICE_ADDR, 1'b1, 8'h40);
        can_mode_i <= TRX_OFF;
        canf <= 4'h8;
        tick(8);
        rd(BUS_ADDR, 1'b0, 8'h00);
        can_mode_i <= TRX_WAKE;
        tick(8);
        rd(BUS_ADDR, 1'b0, 8'h00);
        can_wake_seen_i <= 1'b1;
        tick(8);
        canf <= 4'h0;
        tick(8);
        rd(BUS_ADDR, 1'b1, 8'h01);
        rd(BUS_ADDR, 1'b0, 8'h00);
        can_mode_i <= TRX_NORMAL;
        for (int t = 0; t < 2; t++) begin
            for (int k = 1; k < (t ? 5 : 4); k++) bus_case(t, k);
        end
        finish_test();
    end
endmodule
bind fault_status_bank fault_status_bank_chk u_chk (.*);
